/* File: inc/bit_consts.vh */
// Purpose: constants for the basic interval timer
// Assumes: registers on a plain address/strobe port, 8-bit data
// Notes: offsets are byte addresses on that port
`ifndef BIT_CONSTS_VH
`define BIT_CONSTS_VH
`define BIT_ADDR_W 8
`define BIT_OFF_MODE 8'hd8
`define BIT_OFF_COUNT 8'hd9
`define BIT_OFF_IRQ_STAT 8'hda
`define BIT_OFF_IRQ_MASK 8'hdb
`define BIT_MODE_RESET 8'h00
`define BIT_COUNT_RESET 8'h00
`define BIT_MODE_MASK 8'hf1
`define BIT_RUN_BIT 7
`define BIT_RATE_HI 6
`define BIT_RATE_LO 4
`define BIT_SRC_BIT 0
`define BIT_IRQ_OVF_BIT 0
`define BIT_DIV_W 8
`define BIT_RTC_HZ 32768
`define BIT_HALF_SEC_DIV 64
`define BIT_RTC_DIV_W 6
`define BIT_COUNT_MAX 8'hff
`define BIT_PRE_FULL 8'hff
`define BIT_RTC_DIV_LAST 6'h3f
`endif

/* File: verilog/bit_prescaler.v */
// Purpose: free-running divider of the instruction clock, one tick per selected period
// Assumes: cpuTick is one clock wide at the instruction rate
// Notes: divider restarts while the timer is stopped so the first period is whole
`timescale 1ns/1ps
`include "bit_consts.vh"
module bit_prescaler (
  clock,
  reset_n,
  run,
  cpuTick,
  rateSel,
  tick
);
  input clock;
  input reset_n;
  input run;
  input cpuTick;
  input [2:0] rateSel;
  output tick;
  reg [`BIT_DIV_W-1:0] div_q;
  wire [`BIT_DIV_W-1:0] div_d;
  wire [`BIT_DIV_W-1:0] limit;
  // code 000 divides by 256, 111 by 2
  assign limit = `BIT_PRE_FULL >> rateSel;
  assign tick = run & cpuTick & (div_q >= limit);
  assign div_d = !run ? 8'h00 : !cpuTick ? div_q : tick ? 8'h00 : div_q + 8'h01;
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_d;
    end
  end
endmodule

/* File: verilog/bit_rtc_divider.v */
// Purpose: makes a count tick from the real-time source so 256 ticks span half a second
// Assumes: rtcTick is one clock wide per 32768Hz period, synchronous to clock
// Notes: 32768/2/256 gives one tick every 64 source periods
`timescale 1ns/1ps
`include "bit_consts.vh"
module bit_rtc_divider (
  clock,
  reset_n,
  run,
  rtcTick,
  tick
);
  input clock;
  input reset_n;
  input run;
  input rtcTick;
  output tick;
  reg [`BIT_RTC_DIV_W-1:0] cnt_q;
  assign tick = run & rtcTick & (cnt_q == `BIT_RTC_DIV_LAST);
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= 6'h00;
    end else if (!run) begin
      cnt_q <= 6'h00;
    end else if (rtcTick) begin
      cnt_q <= cnt_q + 6'h01;
    end
  end
endmodule

/* File: verilog/bit_basic_interval_timer.v */
// Purpose: 8-bit up-counting interval timer with divided or real-time count clock
// Assumes: single clock; cpuTick and rtcTick are synchronous one-cycle enables
// Notes: reads return data in the cycle after the read strobe
//   overflow status at da and its enable at db use bit 0 only
//   a stopped timer keeps its count; only a software write changes it
//
// Operation
// - counts up over 8 bits, wraps ff to 00, keeps counting, raises overflow request
// - mode bit 7 set runs the timer, clear stops it
// - mode bits 6:4 pick instruction clock divided by 256 down to 2
// - mode bit 0 picks real-time source instead of divided instruction clock
// - real-time mode ignores prescale and overflows every half second
// - real-time mode exists only with the rc-plus-rtc build option
// - overflow wakes the system from green mode while the timer runs
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
`include "bit_consts.vh"
module bit_basic_interval_timer #(
  parameter INTERNAL_RC_WITH_RTC_OPTION = 1
) (
  clock,
  reset_n,
  cpuTick,
  rtcTick,
  regAddr,
  regWrData,
  regWrite,
  regRead,
  regRdData,
  timerIrq,
  greenWake
);
  input clock;
  input reset_n;
  input cpuTick;
  input rtcTick;
  input [`BIT_ADDR_W-1:0] regAddr;
  input [7:0] regWrData;
  input regWrite;
  input regRead;
  output [7:0] regRdData;
  output timerIrq;
  output greenWake;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // every register has its next value worked out in a combinational block beside it
  reg [7:0] mode_q;
  reg [7:0] mode_d;
  reg [7:0] count_q;
  reg [7:0] count_d;
  reg overflowRequestFlag_q;
  reg overflowRequestFlag_d;
  reg overflowIrqEnable_q;
  reg overflowIrqEnable_d;
  reg [7:0] rdData_q;
  reg [7:0] rdData_d;
  reg wake_q;
  reg wake_d;
  reg modeWr;
  reg countWr;
  reg statWr;
  reg maskWr;
  reg countTick;

  wire countRunEnable;
  wire rtcSourceSel;
  wire [2:0] clockPrescaleSel;
  wire preRun;
  wire rtcRun;
  wire divTick;
  wire rtcCountTick;
  wire countAtMax;
  wire overflow;
  wire statClear;
  wire [7:0] modeView;
  wire [7:0] statView;
  wire [7:0] maskView;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  function hit;
    input [`BIT_ADDR_W-1:0] a;
    input [`BIT_ADDR_W-1:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  // places one status or mask bit in its byte; the other bits read zero
  function [7:0] bitByte;
    input b;
    begin
      bitByte = 8'h00;
      bitByte[`BIT_IRQ_OVF_BIT] = b;
    end
  endfunction

  // at most one write select is high; an unmapped address raises none
  always @* begin
    modeWr = 1'b0;
    countWr = 1'b0;
    statWr = 1'b0;
    maskWr = 1'b0;
    if (!regWrite) begin
      modeWr = 1'b0;
    end else if (hit(regAddr, `BIT_OFF_MODE)) begin
      modeWr = 1'b1;
    end else if (hit(regAddr, `BIT_OFF_COUNT)) begin
      countWr = 1'b1;
    end else if (hit(regAddr, `BIT_OFF_IRQ_STAT)) begin
      statWr = 1'b1;
    end else if (hit(regAddr, `BIT_OFF_IRQ_MASK)) begin
      maskWr = 1'b1;
    end
  end

  // only a one clears; writing zero leaves a pending request alone
  assign statClear = statWr & regWrData[`BIT_IRQ_OVF_BIT];

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  assign countRunEnable = mode_q[`BIT_RUN_BIT];
  assign clockPrescaleSel = mode_q[`BIT_RATE_HI:`BIT_RATE_LO];
  // without the build option the source bit is forced off and reads as zero
  assign rtcSourceSel = mode_q[`BIT_SRC_BIT] & (INTERNAL_RC_WITH_RTC_OPTION != 0);
  // bits 3:1 are never stored, so they read zero
  assign modeView = {mode_q[7:1], rtcSourceSel};

  always @* begin
    mode_d = mode_q;
    if (modeWr) begin
      mode_d = regWrData & `BIT_MODE_MASK;
    end
  end

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mode_q <= `BIT_MODE_RESET;
    end else begin
      mode_q <= mode_d;
    end
  end

  // ----------------------------------------
  // count clock
  // ----------------------------------------
  // each divider is held at zero while its path is idle, so a start or a
  // source change begins with a whole count period
  assign preRun = countRunEnable & !rtcSourceSel;
  assign rtcRun = countRunEnable & rtcSourceSel;

  bit_prescaler uPre (
    .clock(clock),
    .reset_n(reset_n),
    .run(preRun),
    .cpuTick(cpuTick),
    .rateSel(clockPrescaleSel),
    .tick(divTick)
  );

  // prescale field is not looked at on this path
  bit_rtc_divider uRtc (
    .clock(clock),
    .reset_n(reset_n),
    .run(rtcRun),
    .rtcTick(rtcTick),
    .tick(rtcCountTick)
  );

  // only one of the two dividers runs at a time, the other stays silent
  always @* begin
    countTick = divTick;
    if (rtcSourceSel) begin
      countTick = rtcCountTick;
    end
  end

  // ----------------------------------------
  // counter
  // ----------------------------------------
  // the counter never stops at the top; the request flag records each wrap
  assign countAtMax = (count_q == `BIT_COUNT_MAX);
  // software write beats a tick in the same cycle, so the loaded value is not skipped
  assign overflow = countTick & countAtMax & !countWr;

  always @* begin
    count_d = count_q;
    if (countWr) begin
      count_d = regWrData;
    end else if (countTick) begin
      count_d = count_q + 8'h01;
    end
  end

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= `BIT_COUNT_RESET;
    end else begin
      count_q <= count_d;
    end
  end

  // ----------------------------------------
  // interrupt status and mask
  // ----------------------------------------
  // set wins over a write-one-to-clear in the same cycle
  always @* begin
    overflowRequestFlag_d = overflowRequestFlag_q;
    if (overflow) begin
      overflowRequestFlag_d = 1'b1;
    end else if (statClear) begin
      overflowRequestFlag_d = 1'b0;
    end
  end

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      overflowRequestFlag_q <= 1'b0;
    end else begin
      overflowRequestFlag_q <= overflowRequestFlag_d;
    end
  end

  // the enable gates the output only; a request is still recorded while masked
  always @* begin
    overflowIrqEnable_d = overflowIrqEnable_q;
    if (maskWr) begin
      overflowIrqEnable_d = regWrData[`BIT_IRQ_OVF_BIT];
    end
  end

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      overflowIrqEnable_q <= 1'b0;
    end else begin
      overflowIrqEnable_q <= overflowIrqEnable_d;
    end
  end

  assign timerIrq = overflowRequestFlag_q & overflowIrqEnable_q;
  assign statView = bitByte(overflowRequestFlag_q);
  assign maskView = bitByte(overflowIrqEnable_q);

  // ----------------------------------------
  // green mode wake
  // ----------------------------------------
  // registered so the wake line is free of decode glitches, at one cycle of latency
  always @* begin
    wake_d = overflow & countRunEnable;
  end

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= wake_d;
    end
  end
  assign greenWake = wake_q;

  // ----------------------------------------
  // read port
  // ----------------------------------------
  // data stand one cycle and then return to zero, so a stale value never lingers
  always @* begin
    rdData_d = 8'h00;
    if (!regRead) begin
      rdData_d = 8'h00;
    end else if (hit(regAddr, `BIT_OFF_MODE)) begin
      rdData_d = modeView;
    end else if (hit(regAddr, `BIT_OFF_COUNT)) begin
      rdData_d = count_q;
    end else if (hit(regAddr, `BIT_OFF_IRQ_STAT)) begin
      rdData_d = statView;
    end else if (hit(regAddr, `BIT_OFF_IRQ_MASK)) begin
      rdData_d = maskView;
    end else begin
      rdData_d = 8'h00;
    end
  end

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rdData_q <= 8'h00;
    end else begin
      rdData_q <= rdData_d;
    end
  end
  assign regRdData = rdData_q;
endmodule

/* File: verif/bit_timer_asserts.sv */
// Purpose: port checks for the interval timer
// Assumes: sees only the timer top ports
// Notes: bound at the foot of this file
`timescale 1ns/1ps
`include "bit_consts.vh"
module bit_timer_asserts #(
  parameter INTERNAL_RC_WITH_RTC_OPTION = 1
) (
  clock,
  reset_n,
  cpuTick,
  rtcTick,
  regAddr,
  regWrData,
  regWrite,
  regRead,
  regRdData,
  timerIrq,
  greenWake
);
  input clock;
  input reset_n;
  input cpuTick;
  input rtcTick;
  input [`BIT_ADDR_W-1:0] regAddr;
  input [7:0] regWrData;
  input regWrite;
  input regRead;
  input [7:0] regRdData;
  input timerIrq;
  input greenWake;
  // ----------------
  // properties
  // ----------------
  localparam [7:0] MODE_M = INTERNAL_RC_WITH_RTC_OPTION ? 8'hf1 : 8'hf0;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  sequence s_cntWrRd;
    regWrite && regAddr == `BIT_OFF_COUNT ##1 regRead && regAddr == `BIT_OFF_COUNT;
  endsequence
  sequence s_modeWrRd;
    regWrite && regAddr == `BIT_OFF_MODE ##1 regRead && regAddr == `BIT_OFF_MODE;
  endsequence
  property p_rdIdle; !$past(regRead) |-> regRdData == 8'h00; endproperty
  property p_unmapped; $past(regRead) && $past(regAddr[7:2]) != 6'h36 |-> regRdData == 8'h00; endproperty
  property p_stop; regWrite && regAddr == `BIT_OFF_MODE && !regWrData[7] |-> ##2 !greenWake [*6]; endproperty
  property p_wake; greenWake |=> !greenWake; endproperty
  property p_mask; regWrite && regAddr == `BIT_OFF_IRQ_MASK && !regWrData[0] |=> !timerIrq; endproperty
  // a clear loses to an overflow in the same cycle
  property p_clear; regWrite && regAddr == `BIT_OFF_IRQ_STAT && regWrData[0] |=> !timerIrq || greenWake; endproperty
  property p_sticky; timerIrq && !(regWrite && regAddr[7:1] == 7'h6d) |=> timerIrq; endproperty
  property p_cnt; s_cntWrRd |=> (regRdData - $past(regWrData, 2)) <= 8'h01; endproperty
  property p_mode; s_modeWrRd |=> regRdData == ($past(regWrData, 2) & MODE_M); endproperty
  a_rdIdle: assert property (p_rdIdle) else $error("read data outside slot");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_stop: assert property (p_stop) else $error("wake while stopped");
  a_wake: assert property (p_wake) else $error("wake longer than a cycle");
  a_mask: assert property (p_mask) else $error("irq while masked");
  a_clear: assert property (p_clear) else $error("irq after clear");
  a_sticky: assert property (p_sticky) else $error("irq dropped");
  a_cnt: assert property (p_cnt) else $error("count load wrong");
  a_mode: assert property (p_mode) else $error("mode readback wrong");
endmodule
bind bit_basic_interval_timer bit_timer_asserts #(.INTERNAL_RC_WITH_RTC_OPTION(INTERNAL_RC_WITH_RTC_OPTION)) uChk (
  .clock(clock), .reset_n(reset_n), .cpuTick(cpuTick), .rtcTick(rtcTick), .regAddr(regAddr),
  .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
  .timerIrq(timerIrq), .greenWake(greenWake));

/* File: verif/bit_basic_interval_timer_test.sv */
// Purpose: self-checking bench for the interval timer
// Assumes: cpuTick held high, rtcTick high only in real-time test
// Notes: rtcTick runs fast so half a second fits the run
`timescale 1ns/1ps
`include "bit_consts.vh"
module bit_basic_interval_timer_test;
  reg clock, reset_n, cpuTick, rtcTick, regWrite, regRead;
  reg [7:0] regAddr, regWrData, q, qNoRtc;
  wire [7:0] regRdData, regRdDataNoRtc;
  wire timerIrq, greenWake, timerIrqNoRtc, greenWakeNoRtc;
  integer error_cnt = 0, checks_done = 0, n, r, w;
  bit_basic_interval_timer DUT (.clock(clock), .reset_n(reset_n), .cpuTick(cpuTick), .rtcTick(rtcTick),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .timerIrq(timerIrq), .greenWake(greenWake));
  // same stimulus, built without the real-time option
  bit_basic_interval_timer #(.INTERNAL_RC_WITH_RTC_OPTION(0)) dutNoRtc (.clock(clock), .reset_n(reset_n),
    .cpuTick(cpuTick), .rtcTick(rtcTick), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
    .regRead(regRead), .regRdData(regRdDataNoRtc), .timerIrq(timerIrqNoRtc), .greenWake(greenWakeNoRtc));
  // ----------------
  // helpers
  // ----------------
  initial begin
    clock = 0;
    forever #2.5 clock = ~clock;
  end
  task results;
    begin
      if (error_cnt == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // gap of one edge after each access so a strobe is never set twice in one step
  task wrRd(input [7:0] a, input [7:0] d, input doWr, input doRd);
    begin
      @(posedge clock);
      regAddr <= a;
      regWrData <= d;
      regWrite <= doWr;
      regRead <= !doWr;
      if (doWr) begin
        @(posedge clock);
        regWrite <= 1'b0;
        regRead <= doRd;
      end
      @(posedge clock);
      regRead <= 1'b0;
      #1 q = regRdData;
      qNoRtc = regRdDataNoRtc;
    end
  endtask
  task waitIrq;
    begin
      n = 0;
      w = 0;
      while (timerIrq !== 1'b1 && n < 20000) begin
        @(posedge clock);
        #1 n = n + 1;
        if (greenWake === 1'b1) w = 1;
      end
      @(posedge clock);
      #1 if (greenWake === 1'b1) w = 1;
    end
  endtask
  // ----------------
  // scenarios
  // ----------------
  task tRegs;
    begin
      for (r = 0; r < 4; r = r + 1) begin
        wrRd(8'hd8 + r, 0, 0, 1);
        chk(q, 8'h00);
      end
      wrRd(8'hd8, 8'hff, 1, 1);
      chk(q, 8'hf1);
      chk(qNoRtc, 8'hf0);
      wrRd(8'hdc, 8'hff, 1, 1);
      chk(q, 8'h00);
      wrRd(8'hd8, 8'h00, 1, 0);
    end
  endtask
  task tRate(input [2:0] rt);
    begin
      wrRd(8'hd8, 8'h00, 1, 0);
      wrRd(8'hdb, 8'h00, 1, 0);
      wrRd(8'hda, 8'h01, 1, 0);
      wrRd(8'hd8, {1'b0, rt, 4'h0}, 1, 0);
      wrRd(8'hd9, 8'hfe, 1, 0);
      wrRd(8'hdb, 8'h01, 1, 0);
      wrRd(8'hd8, {1'b1, rt, 4'h0}, 1, 0);
      waitIrq;
      chk(n >= 2 * (256 >> rt) - 4 && n <= 2 * (256 >> rt) - 1, 1);
      chk(w, 1);
      wrRd(8'hda, 8'h01, 1, 0);
      chk(timerIrq, 0);
    end
  endtask
  task tStop;
    begin
      wrRd(8'hd9, 8'h40, 1, 1);
      chk(q - 8'h40 <= 8'h01, 1);
      wrRd(8'hd8, 8'h70, 1, 0);
      wrRd(8'hd9, 8'h10, 1, 0);
      repeat (40) @(posedge clock);
      wrRd(8'hd9, 0, 0, 1);
      chk(q, 8'h10);
    end
  endtask
  task tRtc;
    begin
      wrRd(8'hd9, 8'h00, 1, 0);
      @(posedge clock);
      rtcTick <= 1'b1;
      wrRd(8'hd8, 8'hf1, 1, 0);
      waitIrq;
      chk(n >= 16380 && n <= 16386, 1);
      chk(timerIrqNoRtc, 1);
      wrRd(8'hdb, 8'h00, 1, 0);
      chk(timerIrq, 0);
      wrRd(8'hda, 0, 0, 1);
      chk(q, 8'h01);
      wrRd(8'hdb, 8'h01, 1, 0);
      chk(timerIrq, 1);
      repeat (2) @(posedge clock);
      wrRd(8'hda, 8'h01, 1, 0);
      chk(timerIrq, 0);
    end
  endtask
  initial begin
    reset_n = 0;
    cpuTick = 1;
    rtcTick = 0;
    regWrite = 0;
    regRead = 0;
    regAddr = 0;
    regWrData = 0;
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    tRegs;
    for (r = 0; r < 8; r = r + 1) tRate(r);
    tStop;
    tRtc;
    results;
  end
  // the real-time interval dominates the run, about 17k cycles
  initial begin
    repeat (40000) @(posedge clock);
    error_cnt = error_cnt + 1;
    results;
  end
endmodule
